// ### rtl/dpt_pkg.sv
// package for the dual channel prescaled timer: register map and layouts
// assumes a 32-bit apb slave port and one 100 MHz clock
package dpt_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 8;
  localparam int unsigned SEL_W = 2;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL0 = 12'h000;
  localparam logic [11:0] OFF_LIMIT0 = 12'h004;
  localparam logic [11:0] OFF_COUNT0 = 12'h008;
  localparam logic [11:0] OFF_CTRL1 = 12'h010;
  localparam logic [11:0] OFF_LIMIT1 = 12'h014;
  localparam logic [11:0] OFF_COUNT1 = 12'h018;
  localparam logic [11:0] OFF_STATUS = 12'h020;
  localparam logic [11:0] OFF_MASK = 12'h024;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  // control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CTRL_PRE_LSB = 8;
  // reset values
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // input clock divide choices: 100 MHz /1, /4, /16, /64
  localparam logic [7:0] SEL_DIV0 = 8'h01;
  localparam logic [7:0] SEL_DIV1 = 8'h04;
  localparam logic [7:0] SEL_DIV2 = 8'h10;
  localparam logic [7:0] SEL_DIV3 = 8'h40;
  typedef enum logic {DPT_AUTO, DPT_SINGLE} dpt_mode_t;
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [SEL_W-1:0] sel;
    dpt_mode_t mode;
    logic en;
  } dpt_ctrl_t;
endpackage

// ### rtl/dpt_timer.sv
// dual channel prescaled timer with apb slave, sticky status and mask
// assumes one clock clk (100 MHz), synchronous reset srst, apb master
// Notes on behaviour
// - two independent channels, each with 16-bit counter and own prescaler.
// - 8-bit prescaler divides selected clock by 1 to 256.
// - software picks prescaler input frequency through a control field.
// - auto-reload: at period end raise interrupt, clear counter, keep counting.
// - single-shot: at period end raise interrupt, stop, clear own enable.
// - timer is an apb slave; software configures it only over apb.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dpt_timer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [dpt_pkg::DATA_W-1:0] pwdata,
  output logic [dpt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  localparam int unsigned NCH = dpt_pkg::NUM_CH;
  localparam int unsigned CW = dpt_pkg::CNT_W;
  localparam int unsigned PW = dpt_pkg::PRE_W;

  // the register layout only serves these sizes
  if (NCH != 2 || CW != 16 || PW != 8) begin : g_bad_size
    $error("timer sizes do not fit the register map");
  end
  if ($bits(dpt_pkg::dpt_ctrl_t) != 12) begin : g_bad_ctrl
    $error("control layout width wrong");
  end

  // place control fields at their register bit positions
  function automatic logic [31:0] ctrl_word(input dpt_pkg::dpt_ctrl_t c);
    logic [31:0] w;
    w = '0;
    w[dpt_pkg::CTRL_EN_BIT] = c.en;
    w[dpt_pkg::CTRL_MODE_BIT] = c.mode;
    w[dpt_pkg::CTRL_SEL_LSB +: dpt_pkg::SEL_W] = c.sel;
    w[dpt_pkg::CTRL_PRE_LSB +: dpt_pkg::PRE_W] = c.pre;
    return w;
  endfunction

  // selected divider for the input clock choice
  function automatic logic [7:0] sel_div(input logic [1:0] s);
    case (s)
      2'd0: sel_div = dpt_pkg::SEL_DIV0;
      2'd1: sel_div = dpt_pkg::SEL_DIV1;
      2'd2: sel_div = dpt_pkg::SEL_DIV2;
      default: sel_div = dpt_pkg::SEL_DIV3;
    endcase
  endfunction

  // apb decode; one wait-free access phase
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic [11:0] a12 = 12'(paddr);
  wire logic hit_status = (a12 == dpt_pkg::OFF_STATUS);
  wire logic hit_mask = (a12 == dpt_pkg::OFF_MASK);
  wire logic [NCH-1:0] hit_ctrl;
  wire logic [NCH-1:0] hit_limit;
  wire logic [NCH-1:0] hit_count;

  dpt_pkg::dpt_ctrl_t ctrl_q [NCH];
  logic [CW-1:0] limit_q [NCH];
  logic [CW-1:0] cnt_q [NCH];
  logic [PW-1:0] pre_q [NCH];
  logic [7:0] sdiv_q [NCH];
  logic [NCH-1:0] status_q;
  logic [NCH-1:0] mask_q;
  logic [NCH-1:0] done;
  logic [NCH-1:0] tick;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam logic [11:0] BASE = 12'(g) * dpt_pkg::CH_STRIDE;
      assign hit_ctrl[g] = (a12 == dpt_pkg::OFF_CTRL0 + BASE);
      assign hit_limit[g] = (a12 == dpt_pkg::OFF_LIMIT0 + BASE);
      assign hit_count[g] = (a12 == dpt_pkg::OFF_COUNT0 + BASE);
      wire logic en = ctrl_q[g].en;
      // source enable from the selected input clock divide
      wire logic [7:0] sdiv_top = sel_div(ctrl_q[g].sel) - 8'h01;
      wire logic src = en && (sdiv_q[g] == sdiv_top);
      // prescaler: field value n divides by n+1, so 1..256
      wire logic pre_wrap = src && (pre_q[g] == ctrl_q[g].pre);
      assign tick[g] = pre_wrap;
      assign done[g] = tick[g] && (cnt_q[g] == limit_q[g]);
      wire logic ctrl_wr = wr && hit_ctrl[g];

      always_ff @(posedge clk) begin
        // a control write restarts the whole period, dividers included
        if (srst || !en || ctrl_wr || src && sdiv_q[g] == sdiv_top) begin
          sdiv_q[g] <= 8'h00;
        end else begin
          sdiv_q[g] <= sdiv_q[g] + 8'h01;
        end
      end

      always_ff @(posedge clk) begin
        // without the write clear a smaller new ratio would skip to 256
        if (srst || !en || ctrl_wr || pre_wrap) begin
          pre_q[g] <= '0;
        end else if (src) begin
          pre_q[g] <= pre_q[g] + 8'h01;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          ctrl_q[g] <= dpt_pkg::dpt_ctrl_t'(dpt_pkg::CTRL_RST[11:0]);
        end else if (ctrl_wr) begin
          // software write to enable beats the single-shot self clear
          ctrl_q[g] <= dpt_pkg::dpt_ctrl_t'(
            {pwdata[dpt_pkg::CTRL_PRE_LSB +: 8],
             pwdata[dpt_pkg::CTRL_SEL_LSB +: 2],
             pwdata[dpt_pkg::CTRL_MODE_BIT],
             pwdata[dpt_pkg::CTRL_EN_BIT]});
        end else if (done[g] && ctrl_q[g].mode == dpt_pkg::DPT_SINGLE) begin
          ctrl_q[g].en <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          limit_q[g] <= dpt_pkg::LIMIT_RST;
        end else if (wr && hit_limit[g]) begin
          limit_q[g] <= pwdata[CW-1:0];
        end
      end

      // counter restarts from zero on any control write; holds when stopped
      always_ff @(posedge clk) begin
        if (srst || ctrl_wr) begin
          cnt_q[g] <= '0;
        end else if (done[g]) begin
          cnt_q[g] <= '0;
        end else if (tick[g]) begin
          cnt_q[g] <= cnt_q[g] + 16'h0001;
        end
      end

      single_stop_a: assert property (@(posedge clk) disable iff (srst)
        done[g] && ctrl_q[g].mode == dpt_pkg::DPT_SINGLE && !ctrl_wr
        |=> !ctrl_q[g].en && cnt_q[g] == '0)
        else $error("single shot did not stop");
      auto_keep_a: assert property (@(posedge clk) disable iff (srst)
        done[g] && ctrl_q[g].mode == dpt_pkg::DPT_AUTO && !ctrl_wr
        |=> ctrl_q[g].en && cnt_q[g] == '0)
        else $error("auto reload did not keep running");
      cnt_step_a: assert property (@(posedge clk) disable iff (srst)
        tick[g] && !done[g] && !ctrl_wr
        |=> cnt_q[g] == $past(cnt_q[g]) + 16'h0001)
        else $error("counter step wrong");
      limit_end_a: assert property (@(posedge clk) disable iff (srst)
        done[g] |-> cnt_q[g] == limit_q[g] && tick[g])
        else $error("period end without limit match");
      pre_div_a: assert property (@(posedge clk) disable iff (srst)
        tick[g] |-> pre_q[g] == ctrl_q[g].pre && src)
        else $error("prescaler tick early");
      sel_rate_a: assert property (@(posedge clk) disable iff (srst)
        src && ctrl_q[g].sel == 2'd1 && $stable(ctrl_q[g])
        |=> !src [*3])
        else $error("input clock choice ignored");

      status_set_a: assert property (
        @(posedge clk) disable iff (srst)
        done[g] |=> status_q[g])
        else $error("period end did not set status");
      status_clr_a: assert property (
        @(posedge clk) disable iff (srst)
        wr && hit_status && pwdata[g] && !done[g] |=> !status_q[g])
        else $error("status not cleared by write one");
      status_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        status_q[g] && !(wr && hit_status && pwdata[g]) |=> status_q[g])
        else $error("status bit not sticky");
      limit_wr_a: assert property (
        @(posedge clk) disable iff (srst)
        wr && hit_limit[g] |=> limit_q[g] == $past(pwdata[CW-1:0]))
        else $error("limit write lost");
      ctrl_restart_a: assert property (
        @(posedge clk) disable iff (srst)
        ctrl_wr |=> cnt_q[g] == '0)
        else $error("control write did not restart counter");
      cnt_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        !tick[g] && !ctrl_wr |=> $stable(cnt_q[g]))
        else $error("counter moved without tick");
      off_still_a: assert property (
        @(posedge clk) disable iff (srst)
        !en |-> !tick[g])
        else $error("disabled channel ticked");
      pre_bound_a: assert property (
        @(posedge clk) disable iff (srst)
        pre_q[g] <= ctrl_q[g].pre)
        else $error("prescaler ran past its ratio");
      sdiv_bound_a: assert property (
        @(posedge clk) disable iff (srst)
        sdiv_q[g] <= sdiv_top)
        else $error("input divider ran past its choice");
    end
  endgenerate

  // sticky status: set wins over write-one-to-clear
  wire logic [NCH-1:0] st_clr = (wr && hit_status) ? pwdata[NCH-1:0] : '0;
  wire logic [NCH-1:0] status_d = (status_q & ~st_clr) | done;
  // irq uses the next mask too, so a mask write takes hold at once
  wire logic [NCH-1:0] mask_d = (wr && hit_mask) ? pwdata[NCH-1:0] : mask_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // read mux; unmapped addresses read zero and signal pslverr
  wire logic mapped = hit_status || hit_mask || (|hit_ctrl) ||
    (|hit_limit) || (|hit_count);
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    if (hit_status) begin
      rd = 32'(status_q);
    end else if (hit_mask) begin
      rd = 32'(mask_q);
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (hit_ctrl[i]) rd = ctrl_word(ctrl_q[i]);
        else if (hit_limit[i]) rd = {16'h0, limit_q[i]};
        else if (hit_count[i]) rd = {16'h0, cnt_q[i]};
      end
    end
  end

  // registered answer: pready one cycle after setup, in the first access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd : '0;
      irq <= |(status_d & mask_d);
    end
  end

  apb_wait_a: assert property (@(posedge clk) disable iff (srst)
    psel && !penable |=> pready)
    else $error("apb answer not after one wait");
  irq_lvl_a: assert property (@(posedge clk) disable iff (srst)
    |(status_q & mask_q) |-> irq)
    else $error("irq low with unmasked status");
  irq_clear_a: assert property (
    @(posedge clk) disable iff (srst)
    !(|(status_q & mask_q)) |-> !irq)
    else $error("irq high with nothing unmasked");
  pready_pulse_a: assert property (
    @(posedge clk) disable iff (srst)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  err_map_a: assert property (
    @(posedge clk) disable iff (srst)
    psel && !penable && !mapped |=> pslverr && pready)
    else $error("unmapped access without error");
  wr_rdata_a: assert property (
    @(posedge clk) disable iff (srst)
    psel && !penable && pwrite |=> prdata == '0)
    else $error("read data driven on a write");
endmodule
`default_nettype wire

// ### verif/dpt_apb_master.sv
// apb master model standing in for processor software
// assumes the timer answers with pready; every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module dpt_apb_master (
  // clock
  input wire logic clk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err,
    output logic ok);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    ok = (n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so no signal is driven twice in a step
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/dpt_timer_bench.sv
// self-checking bench for the dual channel prescaled timer
// assumes the register map of dpt_pkg and a wait-free apb slave
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int mismatches = 0;
  int checked = 0;
  int n;
  always #5 clk = ~clk;
  dpt_timer dpt_timer_inst (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  dpt_apb_master dpt_apb_master_inst (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic acc(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    logic ok;
    dpt_apb_master_inst.xfer(wr, a, d, q, err, ok);
    if (!ok) begin
      mismatches++;
      test_done();
    end
  endtask
  // cycles until irq rises, bounded
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      test_done();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    acc(0, dpt_pkg::OFF_LIMIT1, 0);
    check("limit1 reset", q, 32'h0000_ffff);
    acc(0, dpt_pkg::OFF_CTRL0, 0);
    check("ctrl0 reset", q, 32'h0000_0000);
    acc(0, 12'h030, 0);
    check("unmapped err", {31'h0, err}, 32'h1);
    $display("test reset done");
    acc(1, dpt_pkg::OFF_LIMIT0, 32'h3);
    acc(1, dpt_pkg::OFF_MASK, 32'h1);
    acc(1, dpt_pkg::OFF_CTRL0, 32'h1);
    wait_irq();
    acc(0, dpt_pkg::OFF_COUNT0, 0);
    check("count0 wraps", {31'h0, q <= 3}, 32'h1);
    acc(0, dpt_pkg::OFF_CTRL0, 0);
    check("auto stays on", q, 32'h1);
    acc(1, dpt_pkg::OFF_CTRL0, 32'h0);
    acc(1, dpt_pkg::OFF_STATUS, 32'h1);
    acc(0, dpt_pkg::OFF_STATUS, 0);
    check("status cleared", q, 32'h0);
    $display("test auto reload done");
    acc(1, dpt_pkg::OFF_LIMIT1, 32'h2);
    acc(1, dpt_pkg::OFF_MASK, 32'h2);
    // prescale /2 on the /4 input: 3 ticks of 8 clocks
    acc(1, dpt_pkg::OFF_CTRL1, 32'h113);
    wait_irq();
    check("single period", {31'h0, n >= 18 && n <= 26}, 32'h1);
    acc(0, dpt_pkg::OFF_CTRL1, 0);
    check("single off", q, 32'h112);
    repeat (20) @(posedge clk);
    acc(0, dpt_pkg::OFF_COUNT1, 0);
    check("single halted", q, 32'h0);
    acc(1, dpt_pkg::OFF_MASK, 32'h0);
    check("masked irq", {31'h0, irq}, 32'h0);
    acc(0, dpt_pkg::OFF_STATUS, 0);
    check("status ch1", q, 32'h2);
    $display("test single shot done");
    test_done();
  end
endmodule
`default_nettype wire
